// [core/ocsc_pkg.sv]
// Constants, types and rule summary for the output clock selection block
// Summary of operation
// R1 - First output standard low codes: off, tones, synths
// R2 - First standard 0101-1010: main APLL divided
// R3 - Standard 1011-1111: auxiliary APLL divided, both outputs
// R4 - First alternate 0000-0110: off, APLL divisions; the code decodes 0101 as undefined
// R5 - First alternate 1000 main reference; others undefined
// R6 - First alternate bit picks first decode table
// R7 - Second standard 0001-1010: tones, synth, main APLL
// R8 - Second alternate 0001-0110: aux and MAIN_APLL_SECOND_OUTPUT divisions
// R9 - Second alternate 0111/1000 references; rest undefined; the code decodes 0000 as off
// R10 - Second alternate bit picks second decode table
// R11 - First selector default taken from first straps
// R12 - Second selector default taken from second straps
// R13 - Multiframe output 2kHz when enabled, else low
// R14 - Frame output 8kHz when enabled, else low
// R15 - Aux field sets synth only when not sourced-from-main
// R16 - Aux code 0000 disables APLL, output low
// R17 - Aux codes 0001-0101 select first five rates
// R18 - Aux codes 0110-1100 select more; 1101-1111 unused
// R19 - Aux field default from both outputs' straps
// R20 - Alternate bit: 0 standard, 1 alternate decodes
// R21 - Sourced-from-main takes main-to-aux field instead
// R22 - Register writes act at once, no reset needed
package ocsc_pkg;

	// Register offsets
	localparam logic [7:0] ALT_DECODE_ADDR    = 8'h4f;
	localparam logic [7:0] FIRST_SEL_ADDR     = 8'h61;
	localparam logic [7:0] SECOND_SEL_ADDR    = 8'h62;
	localparam logic [7:0] FS_ENABLE_ADDR     = 8'h63;
	localparam logic [7:0] AUX_APLL_ADDR      = 8'h64;
	localparam logic [7:0] MAIN_APLL_ADDR     = 8'h65;

	// Field positions
	localparam int SECOND_ALT_BIT   = 5;
	localparam int FIRST_ALT_BIT    = 2;
	localparam int FIRST_SEL_LSB    = 0;
	localparam int SECOND_SEL_LSB   = 4;
	localparam int MFS_EN_BIT       = 7;
	localparam int FS_EN_BIT        = 6;
	localparam int AUX_FREQ_LSB     = 0;
	localparam int AUX_FROM_MAIN_BIT = 6;
	localparam int MAIN_TO_AUX_LSB  = 3;
	localparam int MAIN_FREQ_LSB    = 0;

	// Reset values
	localparam logic [7:0] ALT_DECODE_RESET = 8'h00;
	localparam logic [7:0] FS_ENABLE_RESET  = 8'hc0;
	localparam logic [3:0] AUX_DISABLED     = 4'h0;

	// Timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int FS_PERIOD_NS   = 125000;
	localparam int MFS_PERIOD_NS  = 500000;
	localparam int FS_CYCLES      = FS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MFS_PER_FS     = MFS_PERIOD_NS / FS_PERIOD_NS;

	typedef enum logic [3:0] {
		SRC_OFF,
		SRC_TONE_2K,
		SRC_TONE_8K,
		SRC_SYNTH_A,
		SRC_SYNTH_B,
		SRC_MAIN_APLL,
		SRC_MAIN_MAIN_APLL_SECOND_OUTPUT,
		SRC_AUX_APLL,
		SRC_MAIN_REF,
		SRC_AUX_REF,
		SRC_UNDEF
	} ocsc_src_type;

	typedef struct packed {
		ocsc_src_type src;
		logic [6:0]   div;
	} ocsc_route_type;

endpackage

// [core/ocsc_tone_gen.sv]
// Enable-gated period counter giving one pulse per period
`timescale 1ns/1ps
module ocsc_tone_gen #(
	parameter int PERIOD = 4
) (
	input  wire logic clk_i,     // System clock
	input  wire logic reset_n_i, // Async reset, active low
	input  wire logic en_i,      // Count enable
	output logic      pulse_o    // One-cycle end of period
);
	localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

	if (PERIOD < 2) begin : g_bad_period
		$error("ocsc_tone_gen: PERIOD must be at least 2");
	end

	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	wire           wrap = (count_r == CW'(PERIOD - 1));

	assign count_nxt = wrap ? '0 : count_r + CW'(1);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_r <= '0;
			pulse_o <= 1'b0;
		end else begin
			pulse_o <= en_i & wrap;
			if (en_i)
				count_r <= count_nxt;
		end
	end
endmodule

// [core/ocsc_sel_decode.sv]
// Frequency selector decode for one clock output
`timescale 1ns/1ps
module ocsc_sel_decode #(
	parameter bit SECOND = 1'b0
) (
	input  wire logic [3:0]     sel_i,    // Selector code
	input  wire logic           alt_i,    // Alternate decode select
	input  wire logic           aux_on_i, // Aux APLL running
	output ocsc_pkg::ocsc_route_type route_o // Source and divisor
);
	function automatic ocsc_pkg::ocsc_route_type mk(
		input ocsc_pkg::ocsc_src_type s,
		input logic [6:0] d
	);
		ocsc_pkg::ocsc_route_type r;
		r.src = s;
		r.div = d;
		return r;
	endfunction

	function automatic ocsc_pkg::ocsc_route_type std_dec(
		input logic [3:0] s
	);
		case (s)
		4'h0: return mk(ocsc_pkg::SRC_OFF, 7'h01);
		4'h1: return mk(ocsc_pkg::SRC_TONE_2K, 7'h01);
		4'h2: return mk(ocsc_pkg::SRC_TONE_8K, 7'h01);
		4'h3: return SECOND ? mk(ocsc_pkg::SRC_MAIN_APLL, 7'h02) // R7
			: mk(ocsc_pkg::SRC_SYNTH_B, 7'h01); // R1
		4'h4: return mk(ocsc_pkg::SRC_SYNTH_A, 7'h01);
		4'h5: return mk(ocsc_pkg::SRC_MAIN_APLL, SECOND ? 7'h01 : 7'h30); // R2
		4'h6: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h10);
		4'h7: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h0c);
		4'h8: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h08);
		4'h9: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h06);
		4'ha: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h04);
		4'hb: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h40); // R3
		4'hc: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h30);
		4'hd: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h10);
		4'he: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h08);
		default: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h04);
		endcase
	endfunction

	function automatic ocsc_pkg::ocsc_route_type alt_first(
		input logic [3:0] s
	);
		case (s)
		4'h0: return mk(ocsc_pkg::SRC_OFF, 7'h01); // R4
		4'h1: return mk(ocsc_pkg::SRC_MAIN_APLL, 7'h40);
		4'h2: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h14);
		4'h3: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h0c);
		4'h4: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h05);
		4'h6: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h02);
		4'h8: return mk(ocsc_pkg::SRC_MAIN_REF, 7'h01); // R5
		default: return mk(ocsc_pkg::SRC_UNDEF, 7'h01);
		endcase
	endfunction

	function automatic ocsc_pkg::ocsc_route_type alt_second(
		input logic [3:0] s
	);
		case (s)
		4'h0: return mk(ocsc_pkg::SRC_OFF, 7'h01); // R8
		4'h1: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h05);
		4'h2: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h02);
		4'h3: return mk(ocsc_pkg::SRC_AUX_APLL, 7'h01);
		4'h4: return mk(ocsc_pkg::SRC_MAIN_MAIN_APLL_SECOND_OUTPUT, 7'h05);
		4'h5: return mk(ocsc_pkg::SRC_MAIN_MAIN_APLL_SECOND_OUTPUT, 7'h02);
		4'h6: return mk(ocsc_pkg::SRC_MAIN_MAIN_APLL_SECOND_OUTPUT, 7'h01);
		4'h7: return mk(ocsc_pkg::SRC_AUX_REF, 7'h01); // R9
		4'h8: return mk(ocsc_pkg::SRC_MAIN_REF, 7'h01);
		default: return mk(ocsc_pkg::SRC_UNDEF, 7'h01);
		endcase
	endfunction

	ocsc_pkg::ocsc_route_type std_route;
	ocsc_pkg::ocsc_route_type alt_route;
	ocsc_pkg::ocsc_route_type picked;

	assign std_route = std_dec(sel_i);
	assign alt_route = SECOND ? alt_second(sel_i) : alt_first(sel_i);
	assign picked    = alt_i ? alt_route : std_route; // R6 R10 R20
	// A stopped aux APLL has a low output, so route it as off
	assign route_o   = (picked.src == ocsc_pkg::SRC_AUX_APLL && !aux_on_i)
		? mk(ocsc_pkg::SRC_OFF, 7'h01) : picked; // R16
endmodule

// [core/ocsc_top.sv]
// Output clock selection and APLL frequency configuration
`timescale 1ns/1ps
module ocsc_top #(
	parameter int FS_PERIOD  = ocsc_pkg::FS_CYCLES,
	parameter int MFS_RATIO  = ocsc_pkg::MFS_PER_FS
) (
	input  wire logic                 clk_i,          // 25 MHz clock
	input  wire logic                 reset_n_i,      // Async reset
	input  wire logic [2:0]           first_output_strap_i,  // Straps
	input  wire logic [2:0]           second_output_strap_i, // Straps
	input  wire logic [7:0]           reg_addr_i,     // Register address
	input  wire logic                 reg_wr_i,       // Write strobe
	input  wire logic                 reg_rd_i,       // Read strobe
	input  wire logic [7:0]           reg_wdata_i,    // Write data
	output logic [7:0]                reg_rdata_o,    // Read data
	output ocsc_pkg::ocsc_route_type  first_route_o,  // First mux ctl
	output ocsc_pkg::ocsc_route_type  second_route_o, // Second mux ctl
	output logic                      first_clock_output_o,  // Tone out
	output logic                      second_clock_output_o, // Tone out
	output logic                      frame_sync_out_o,      // 8kHz
	output logic                      multiframe_sync_out_o, // 2kHz
	output logic [3:0]                aux_synth_code_o, // Aux rate code
	output logic                      aux_apll_enable_o, // Aux running
	output logic [2:0]                main_apll_freq_o  // Main rate code
);
	if (FS_PERIOD < 2 || MFS_RATIO < 2) begin : g_bad_period
		$error("ocsc_top: frame periods too short");
	end

	// Strap decode for the power-up aux rate: the two strap groups
	// combine into a single code; any result above the table is capped
	function automatic logic [3:0] aux_default(
		input logic [2:0] a,
		input logic [2:0] b
	);
		logic [3:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > 4'hc) ? 4'hc : s;
	endfunction

	// Three-bit main-to-aux code expressed as an aux rate code
	function automatic logic [3:0] main_to_aux_code(
		input logic [2:0] c
	);
		case (c)
		3'h0: return 4'h2;
		3'h1: return 4'h9;
		3'h2: return 4'h3;
		3'h4: return 4'h4;
		3'h6: return 4'h5;
		3'h7: return 4'h8;
		default: return ocsc_pkg::AUX_DISABLED;
		endcase
	endfunction

	logic       loaded_r;
	logic [3:0] first_sel_r;
	logic [3:0] second_sel_r;
	logic       first_alt_r;
	logic       second_alt_r;
	logic       mfs_en_r;
	logic       fs_en_r;
	logic [3:0] aux_freq_r;
	logic       aux_from_main_r;
	logic [2:0] main_to_aux_r;
	logic [2:0] main_freq_r;

	// Writes are held off for the single strap-load cycle
	wire wr_ok      = reg_wr_i & loaded_r;
	wire wr_alt     = wr_ok & (reg_addr_i == ocsc_pkg::ALT_DECODE_ADDR);
	wire wr_first   = wr_ok & (reg_addr_i == ocsc_pkg::FIRST_SEL_ADDR);
	wire wr_second  = wr_ok & (reg_addr_i == ocsc_pkg::SECOND_SEL_ADDR);
	wire wr_fs      = wr_ok & (reg_addr_i == ocsc_pkg::FS_ENABLE_ADDR);
	wire wr_aux     = wr_ok & (reg_addr_i == ocsc_pkg::AUX_APLL_ADDR);
	wire wr_main    = wr_ok & (reg_addr_i == ocsc_pkg::MAIN_APLL_ADDR);

	// Strap-derived defaults, taken once after reset release
	wire [3:0] first_strap_sel  = {1'b0, first_output_strap_i}; // R11
	wire [3:0] second_strap_sel = {1'b0, second_output_strap_i}; // R12
	wire [3:0] aux_strap_freq   =
		aux_default(first_output_strap_i, second_output_strap_i); // R19

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			loaded_r     <= 1'b0;
			first_sel_r  <= 4'h0;
			second_sel_r <= 4'h0;
			aux_freq_r   <= ocsc_pkg::AUX_DISABLED;
			main_freq_r  <= 3'h0;
		end else if (!loaded_r) begin
			loaded_r     <= 1'b1;
			first_sel_r  <= first_strap_sel; // R11
			second_sel_r <= second_strap_sel; // R12
			aux_freq_r   <= aux_strap_freq; // R19
			main_freq_r  <= second_output_strap_i;
		end else begin
			if (wr_first)
				first_sel_r <= reg_wdata_i[ocsc_pkg::FIRST_SEL_LSB +: 4]; // R22
			if (wr_second)
				second_sel_r <= reg_wdata_i[ocsc_pkg::SECOND_SEL_LSB +: 4];
			if (wr_aux)
				aux_freq_r <= reg_wdata_i[ocsc_pkg::AUX_FREQ_LSB +: 4];
			if (wr_main)
				main_freq_r <= reg_wdata_i[ocsc_pkg::MAIN_FREQ_LSB +: 3];
		end
	end

	localparam logic [7:0] AR = ocsc_pkg::ALT_DECODE_RESET;
	localparam logic [7:0] FR = ocsc_pkg::FS_ENABLE_RESET;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			first_alt_r     <= AR[ocsc_pkg::FIRST_ALT_BIT];
			second_alt_r    <= AR[ocsc_pkg::SECOND_ALT_BIT];
			mfs_en_r        <= FR[ocsc_pkg::MFS_EN_BIT];
			fs_en_r         <= FR[ocsc_pkg::FS_EN_BIT];
			aux_from_main_r <= 1'b0;
			main_to_aux_r   <= 3'h0;
		end else begin
			if (wr_alt) begin
				first_alt_r  <= reg_wdata_i[ocsc_pkg::FIRST_ALT_BIT]; // R20
				second_alt_r <= reg_wdata_i[ocsc_pkg::SECOND_ALT_BIT];
			end
			if (wr_fs) begin
				mfs_en_r <= reg_wdata_i[ocsc_pkg::MFS_EN_BIT]; // R22
				fs_en_r  <= reg_wdata_i[ocsc_pkg::FS_EN_BIT];
			end
			if (wr_main) begin
				aux_from_main_r <=
					reg_wdata_i[ocsc_pkg::AUX_FROM_MAIN_BIT];
				main_to_aux_r <=
					reg_wdata_i[ocsc_pkg::MAIN_TO_AUX_LSB +: 3];
			end
		end
	end

	// Read-back; unmapped addresses and reserved bits read zero
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_i)
		ocsc_pkg::ALT_DECODE_ADDR: begin
			rd_mux[ocsc_pkg::FIRST_ALT_BIT]  = first_alt_r;
			rd_mux[ocsc_pkg::SECOND_ALT_BIT] = second_alt_r;
		end
		ocsc_pkg::FIRST_SEL_ADDR:
			rd_mux[ocsc_pkg::FIRST_SEL_LSB +: 4] = first_sel_r;
		ocsc_pkg::SECOND_SEL_ADDR:
			rd_mux[ocsc_pkg::SECOND_SEL_LSB +: 4] = second_sel_r;
		ocsc_pkg::FS_ENABLE_ADDR: begin
			rd_mux[ocsc_pkg::MFS_EN_BIT] = mfs_en_r;
			rd_mux[ocsc_pkg::FS_EN_BIT]  = fs_en_r;
		end
		ocsc_pkg::AUX_APLL_ADDR:
			rd_mux[ocsc_pkg::AUX_FREQ_LSB +: 4] = aux_freq_r;
		ocsc_pkg::MAIN_APLL_ADDR: begin
			rd_mux[ocsc_pkg::AUX_FROM_MAIN_BIT]     = aux_from_main_r;
			rd_mux[ocsc_pkg::MAIN_TO_AUX_LSB +: 3]  = main_to_aux_r;
			rd_mux[ocsc_pkg::MAIN_FREQ_LSB +: 3]    = main_freq_r;
		end
		default:
			rd_mux = 8'h00;
		endcase
	end

	// Effective aux synthesizer code
	wire [3:0] aux_code = aux_from_main_r
		? main_to_aux_code(main_to_aux_r) // R21
		: aux_freq_r; // R15 R17 R18
	// Codes above the table are unused; treat them as stopped
	wire       aux_on   = (aux_code != ocsc_pkg::AUX_DISABLED)
		&& (aux_code <= 4'hc); // R16 R18

	// Frame tones: the 2kHz pulse comes one cycle after every fourth 8kHz pulse
	logic fs_tick;
	logic mfs_tick;

	ocsc_tone_gen #(
		.PERIOD (FS_PERIOD)
	) u_fs_gen (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.en_i      (1'b1),
		.pulse_o   (fs_tick)
	);

	ocsc_tone_gen #(
		.PERIOD (MFS_RATIO)
	) u_mfs_gen (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.en_i      (fs_tick),
		.pulse_o   (mfs_tick)
	);

	ocsc_pkg::ocsc_route_type first_route;
	ocsc_pkg::ocsc_route_type second_route;

	ocsc_sel_decode #(
		.SECOND (1'b0)
	) u_first_dec (
		.sel_i    (first_sel_r),
		.alt_i    (first_alt_r),
		.aux_on_i (aux_on),
		.route_o  (first_route)
	);

	ocsc_sel_decode #(
		.SECOND (1'b1)
	) u_second_dec (
		.sel_i    (second_sel_r),
		.alt_i    (second_alt_r),
		.aux_on_i (aux_on),
		.route_o  (second_route)
	);

	// Tones are made here; other sources belong to the analog mux,
	// so the pin copy stays low for them
	wire first_tone =
		(first_route.src == ocsc_pkg::SRC_TONE_2K && mfs_tick) ||
		(first_route.src == ocsc_pkg::SRC_TONE_8K && fs_tick); // R1
	wire second_tone =
		(second_route.src == ocsc_pkg::SRC_TONE_2K && mfs_tick) ||
		(second_route.src == ocsc_pkg::SRC_TONE_8K && fs_tick); // R7

	localparam ocsc_pkg::ocsc_route_type ROUTE_OFF = '{
		src: ocsc_pkg::SRC_OFF, div: 7'h01};

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o           <= 8'h00;
			first_route_o         <= ROUTE_OFF;
			second_route_o        <= ROUTE_OFF;
			first_clock_output_o  <= 1'b0;
			second_clock_output_o <= 1'b0;
			frame_sync_out_o      <= 1'b0;
			multiframe_sync_out_o <= 1'b0;
			aux_synth_code_o      <= ocsc_pkg::AUX_DISABLED;
			aux_apll_enable_o     <= 1'b0;
			main_apll_freq_o      <= 3'h0;
		end else begin
			if (reg_rd_i)
				reg_rdata_o <= rd_mux;
			first_route_o         <= first_route; // R6
			second_route_o        <= second_route; // R10
			first_clock_output_o  <= first_tone;
			second_clock_output_o <= second_tone;
			frame_sync_out_o      <= fs_en_r & fs_tick; // R14
			multiframe_sync_out_o <= mfs_en_r & mfs_tick; // R13
			aux_synth_code_o      <= aux_on ? aux_code
				: ocsc_pkg::AUX_DISABLED; // R16
			aux_apll_enable_o     <= aux_on; // R15
			main_apll_freq_o      <= main_freq_r;
		end
	end
endmodule

// [testbench/ocsc_top_asserts.sv]
// Port-level assertions for the output clock selection block
`timescale 1ns/1ps
module ocsc_top_asserts #(
	parameter int FS_PERIOD = ocsc_pkg::FS_CYCLES,
	parameter int MFS_RATIO = ocsc_pkg::MFS_PER_FS
) (
	input wire logic                     clk_i,                 // Clock
	input wire logic                     reset_n_i,             // Reset
	input wire logic [2:0]               first_output_strap_i,  // Straps
	input wire logic [2:0]               second_output_strap_i, // Straps
	input wire logic [7:0]               reg_addr_i,            // Address
	input wire logic                     reg_wr_i,              // Write
	input wire logic                     reg_rd_i,              // Read
	input wire logic [7:0]               reg_wdata_i,           // Data in
	input wire logic [7:0]               reg_rdata_o,           // Data out
	input wire ocsc_pkg::ocsc_route_type first_route_o,         // Route
	input wire logic                     frame_sync_out_o,      // 8 kHz
	input wire logic                     multiframe_sync_out_o, // 2 kHz
	input wire logic [3:0]               aux_synth_code_o,      // Aux code
	input wire logic                     aux_apll_enable_o      // Aux on
);
	localparam logic [3:0] MAP [8] = '{4'h2, 4'h9, 4'h3, 4'h0,
		4'h4, 4'h0, 4'h5, 4'h8};
	logic [1:0] up_r;
	logic       fs_en_r, mfs_en_r, from_main_r, fs_seen_r, mfs_seen_r;
	int         fs_gap_r, mfs_gap_r;
	// Writes in the strap-load cycle are dropped by the block
	wire logic       wr_ok     = reg_wr_i && up_r != 2'h0;
	wire logic [3:0] wd_lo     = reg_wdata_i[3:0];
	wire logic [3:0] aux_cap   = (wd_lo > 4'hc) ? 4'h0 : wd_lo;
	wire logic [3:0] map_w     = MAP[reg_wdata_i[5:3]];
	wire logic [4:0] strap_sum = {2'h0, first_output_strap_i} +
		{2'h0, second_output_strap_i};
	wire logic [3:0] strap_min = (strap_sum > 5'h0c) ? 4'hc : strap_sum[3:0];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			up_r        <= 2'h0;
			fs_en_r     <= 1'b1;
			mfs_en_r    <= 1'b1;
			from_main_r <= 1'b0;
		end else begin
			if (up_r != 2'h2)
				up_r <= up_r + 2'h1;
			if (wr_ok && reg_addr_i == ocsc_pkg::FS_ENABLE_ADDR) begin
				fs_en_r  <= reg_wdata_i[6];
				mfs_en_r <= reg_wdata_i[7];
			end
			if (wr_ok && reg_addr_i == ocsc_pkg::MAIN_APLL_ADDR)
				from_main_r <= reg_wdata_i[6];
		end
	end

	// Spacing is only judged between pulses of one enabled stretch
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fs_gap_r   <= 0;
			mfs_gap_r  <= 0;
			fs_seen_r  <= 1'b0;
			mfs_seen_r <= 1'b0;
		end else begin
			fs_gap_r   <= frame_sync_out_o ? 0 : fs_gap_r + 1;
			mfs_gap_r  <= multiframe_sync_out_o ? 0 : mfs_gap_r + 1;
			fs_seen_r  <= fs_en_r && (fs_seen_r || frame_sync_out_o);
			mfs_seen_r <= mfs_en_r && (mfs_seen_r || multiframe_sync_out_o);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_aux_wr;
		wr_ok && reg_addr_i == ocsc_pkg::AUX_APLL_ADDR && !from_main_r
		##1 !(wr_ok && reg_addr_i == ocsc_pkg::MAIN_APLL_ADDR);
	endsequence
	sequence s_first_rb;
		wr_ok && reg_addr_i == ocsc_pkg::FIRST_SEL_ADDR
		##1 reg_rd_i && !reg_wr_i && reg_addr_i == ocsc_pkg::FIRST_SEL_ADDR;
	endsequence

	a_strap_aux_default: assert property ($rose(reset_n_i) |->
		##2 aux_synth_code_o == strap_min)
		else $error("aux code after reset differs from strap default");
	a_aux_field_code: assert property (s_aux_wr |->
		##1 aux_synth_code_o == $past(aux_cap, 2))
		else $error("aux code does not follow aux field write");
	a_main_feeds_aux: assert property (wr_ok && reg_wdata_i[6] &&
		reg_addr_i == ocsc_pkg::MAIN_APLL_ADDR |-> ##2 aux_synth_code_o == $past(map_w, 2))
		else $error("aux code does not follow main-to-aux field");
	a_aux_enable_code: assert property (
		aux_apll_enable_o == (aux_synth_code_o != 4'h0))
		else $error("aux enable disagrees with aux code");
	a_sel_readback: assert property (s_first_rb |=>
		reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h0f))
		else $error("first selector read back wrong");
	a_first_off_code: assert property (wr_ok && wd_lo == 4'h0 &&
		reg_addr_i == ocsc_pkg::FIRST_SEL_ADDR |-> ##2 first_route_o.src == ocsc_pkg::SRC_OFF)
		else $error("first route not off after code zero");
	// Judged on every cycle of a disabled stretch, not just after the write
	a_fs_disabled_low: assert property (!fs_en_r |=> !frame_sync_out_o)
		else $error("frame sync pulses while disabled");
	a_mfs_disabled_low: assert property (!mfs_en_r |=> !multiframe_sync_out_o)
		else $error("multiframe sync pulses while disabled");
	a_fs_pulse_spacing: assert property (frame_sync_out_o && fs_seen_r |->
		(fs_gap_r + 1) % FS_PERIOD == 0)
		else $error("frame sync spacing wrong");
	a_mfs_pulse_spacing: assert property (multiframe_sync_out_o && mfs_seen_r |->
		(mfs_gap_r + 1) % (FS_PERIOD * MFS_RATIO) == 0)
		else $error("multiframe sync spacing wrong");
endmodule

bind ocsc_top ocsc_top_asserts #(
	.FS_PERIOD(FS_PERIOD),
	.MFS_RATIO(MFS_RATIO)
) u_asserts (
	.clk_i, .reset_n_i, .first_output_strap_i, .second_output_strap_i,
	.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
	.first_route_o, .frame_sync_out_o, .multiframe_sync_out_o,
	.aux_synth_code_o, .aux_apll_enable_o
);

// [testbench/ocsc_line_card.sv]
// Downstream line-card model counting clock and sync pulses
`timescale 1ns/1ps
module ocsc_line_card (
	input  wire logic       clk_i,     // System clock
	input  wire logic       reset_n_i, // Async reset, active low
	input  wire logic       clear_i,   // Zero all counters
	input  wire logic [3:0] pulse_i,   // fs, mfs, first, second
	output logic [3:0][15:0] count_o   // Pulses seen per input
);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_o <= '0;
		end else if (clear_i) begin
			count_o <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (pulse_i[i])
					count_o[i] <= count_o[i] + 16'h0001;
			end
		end
	end
endmodule

// [testbench/ocsc_top_test.sv]
// Self-checking bench for the output clock selection block
`timescale 1ns/1ps
module ocsc_top_test;
	localparam int FSP = 8;
	logic [2:0]               strap1      = 3'h2;
	logic [2:0]               strap2      = 3'h3;
	localparam logic [7:0] EN [3] = '{8'hc0, 8'h80, 8'h00};
	localparam logic [3:0] MAP [8] = '{4'h2, 4'h9, 4'h3, 4'h0,
		4'h4, 4'h0, 4'h5, 4'h8};
	// Source code in the top nibble, divisor below; divisor 0 is not judged
	localparam logic [11:0] ROUTE_TAB [64] = '{
		12'h000, 12'h100, 12'h200, 12'h400, 12'h300, 12'h530, 12'h510, 12'h50c,
		12'h508, 12'h506, 12'h504, 12'h740, 12'h730, 12'h710, 12'h708, 12'h704,
		12'h000, 12'h100, 12'h200, 12'h502, 12'h300, 12'h501, 12'h510, 12'h50c,
		12'h508, 12'h506, 12'h504, 12'h740, 12'h730, 12'h710, 12'h708, 12'h704,
		12'h000, 12'h540, 12'h714, 12'h70c, 12'h705, 12'ha00, 12'h702, 12'ha00,
		12'h800, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00,
		12'h000, 12'h705, 12'h702, 12'h701, 12'h605, 12'h602, 12'h601, 12'h900,
		12'h800, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00};
	logic                     clk_i       = 1'b0;
	logic                     reset_n_i   = 1'b0;
	logic                     reg_wr_i    = 1'b0;
	logic                     reg_rd_i    = 1'b0;
	logic                     clear       = 1'b1;
	logic [7:0]               reg_addr_i  = 8'h00;
	logic [7:0]               reg_wdata_i = 8'h00;
	logic [7:0]               reg_rdata_o;
	logic [3:0]               aux_synth_code_o;
	logic [2:0]               main_apll_freq_o;
	logic [3:0][15:0]         count;
	logic                     first_clock_output_o, second_clock_output_o;
	logic                     frame_sync_out_o, multiframe_sync_out_o;
	logic                     aux_apll_enable_o;
	ocsc_pkg::ocsc_route_type first_route_o, second_route_o;
	int                       err_total = 0;
	int                       checked   = 0;

	ocsc_top #(.FS_PERIOD(FSP), .MFS_RATIO(4)) dut (
		.clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
		.first_output_strap_i(strap1), .second_output_strap_i(strap2),
		.reg_rdata_o, .first_route_o, .second_route_o, .first_clock_output_o,
		.second_clock_output_o, .frame_sync_out_o, .multiframe_sync_out_o,
		.aux_synth_code_o, .aux_apll_enable_o, .main_apll_freq_o);
	ocsc_line_card u_card (
		.clk_i, .reset_n_i, .clear_i(clear), .count_o(count),
		.pulse_i({second_clock_output_o, first_clock_output_o,
			multiframe_sync_out_o, frame_sync_out_o}));

	always #20 clk_i = ~clk_i;

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_route(input ocsc_pkg::ocsc_route_type got,
		input logic [11:0] e);
		checked++;
		if (got.src !== e[11:8] || (e[7:0] != 8'h00 && got.div !== e[6:0])) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		idle(1);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = 1'b1;
		idle(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		idle(1);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		idle(1);
		reg_rd_i = 1'b0;
		cmp({8'h00, reg_rdata_o}, {8'h00, e});
	endtask
	// Read issued in the very cycle after the write
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		wr(a, d);
		reg_rd_i = 1'b1;
		idle(1);
		reg_rd_i = 1'b0;
		cmp({8'h00, reg_rdata_o}, {8'h00, e});
	endtask

	task automatic t_defaults;
		logic [7:0] sum;
		sum = {5'h00, strap1} + {5'h00, strap2};
		rd_chk(8'h63, 8'hc0);
		rd_chk(8'h4f, 8'h00);
		rd_chk(8'h61, {5'h00, strap1});
		rd_chk(8'h62, {1'b0, strap2, 4'h0});
		rd_chk(8'h64, (sum > 8'h0c) ? 8'h0c : sum);
		rd_chk(8'h65, {5'h00, strap2});
		rd_chk(8'h70, 8'h00);
	endtask
	// Second power-up with straps whose sum passes the table end
	task automatic t_reset;
		reset_n_i = 1'b0;
		strap1    = 3'h7;
		strap2    = 3'h7;
		idle(3);
		reset_n_i = 1'b1;
		idle(2);
		cmp_route(first_route_o, ROUTE_TAB[7]);
		cmp_route(second_route_o, ROUTE_TAB[23]);
		cmp(aux_synth_code_o, 16'h000c);
		t_defaults;
	endtask
	task automatic t_access;
		wr_rd(8'h61, 8'hff, 8'h0f);
		wr_rd(8'h62, 8'hff, 8'hf0);
		wr_rd(8'h70, 8'hff, 8'h00);
	endtask
	task automatic t_tables;
		for (int alt = 0; alt < 2; alt++) begin
			wr(8'h4f, alt == 1 ? 8'h24 : 8'h00);
			for (int c = 0; c < 16; c++) begin
				wr(8'h61, {4'h0, c[3:0]});
				wr(8'h62, {c[3:0], 4'h0});
				idle(2);
				cmp_route(first_route_o, ROUTE_TAB[alt * 32 + c]);
				cmp_route(second_route_o, ROUTE_TAB[alt * 32 + 16 + c]);
			end
		end
	endtask
	task automatic t_aux;
		wr(8'h4f, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wr(8'h64, {4'h0, c[3:0]});
			idle(2);
			cmp(aux_synth_code_o, c > 12 ? 16'h0000 : c[15:0]);
			cmp(aux_apll_enable_o, c >= 1 && c <= 12);
		end
		wr(8'h61, 8'h0b);
		idle(2);
		cmp_route(first_route_o, 12'h000);
		for (int i = 0; i < 8; i++) begin
			wr(8'h65, {2'h1, i[2:0], 3'h6});
			wr(8'h64, 8'h01);
			idle(2);
			cmp(aux_synth_code_o, MAP[i]);
			cmp(main_apll_freq_o, 3'h6);
		end
		wr(8'h65, 8'h06);
		idle(2);
		cmp(aux_synth_code_o, 16'h0001);
	endtask
	task automatic t_frames;
		wr(8'h61, 8'h02);
		wr(8'h62, 8'h10);
		for (int k = 0; k < 3; k++) begin
			wr(8'h63, EN[k]);
			idle(2 * FSP);
			clear = 1'b1;
			idle(1);
			clear = 1'b0;
			idle(32 * FSP);
			cmp(count[0], k == 0 ? 16'h0020 : 16'h0000);
			cmp(count[1], k < 2 ? 16'h0008 : 16'h0000);
			cmp(count[2], 16'h0020);
			cmp(count[3], 16'h0008);
		end
		wr(8'h63, 8'hc0);
	endtask

	task automatic report_and_stop;
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		idle(2);
		t_defaults;
		t_access;
		t_tables;
		t_aux;
		t_frames;
		t_reset;
		report_and_stop;
	end
	// Whole run is near 1200 cycles, so 5000 cycles means a hang
	initial begin
		#200_000;
		err_total++;
		report_and_stop;
	end
endmodule
